/* fpp_pkg.sv */
// package: register map, field layout and reset values of the four-pin port
package fpp_pkg;
    localparam int DATA_W = 8;
    localparam int NUM_PINS = 4;
    localparam int NUM_IO = 3;
    localparam int INPUT_ONLY_IDX = 3;
    localparam int ADDR_W = 4;

    // register offsets (word index on the plain register port)
    localparam logic [3:0] OFS_PIN_LEVELS = 4'h0;
    localparam logic [3:0] OFS_DIRECTION = 4'h1;
    localparam logic [3:0] OFS_OUTPUT_LATCH = 4'h2;
    localparam logic [3:0] OFS_ANALOG_SELECT = 4'h3;

    // reset values of the implemented control bits
    localparam logic [2:0] DIRECTION_RST = 3'h7;
    localparam logic [2:0] ANALOG_SELECT_RST = 3'h7;
    localparam logic [2:0] LATCH_RST = 3'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // one peripheral output source for a pin
    typedef struct packed {
        logic en;
        logic val;
    } fpp_src_t;

    // register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } fpp_req_t;
endpackage : fpp_pkg

/* fpp_pin_mux.sv */
// file: per-pin fixed-priority output selector
`timescale 1ns/1ps
module fpp_pin_mux (
    input wire fpp_pkg::fpp_src_t lcd_i,
    input wire fpp_pkg::fpp_src_t ccp_i,
    input wire logic latch_i,
    input wire logic dir_input_i,
    output logic drive_o,
    output logic val_o
);
    // lcd wins over ccp, ccp over the port latch
    always_comb begin
        if (lcd_i.en) begin
            drive_o = 1'b1;
            val_o = lcd_i.val;
        end else if (ccp_i.en) begin
            drive_o = 1'b1;
            val_o = ccp_i.val;
        end else begin
            // direction bit gates the latch, analog select never does
            drive_o = ~dir_input_i;
            val_o = latch_i;
        end
    end
endmodule : fpp_pin_mux

/* fpp_port.sv */
// file: top of the four-pin port with analog select and output priority
// Summary of operation
// - analog-selected pins read zero digitally
// - analog select never blocks output drive
// - direction bits control output drivers only when no lcd or ccp source owns the pin
// - analog-select bits reset to one
// - only highest-priority enabled source drives pin
// - priority lcd, then ccp, then latch
// - analog and input paths see pin always
// - port read gives pin levels, upper zero
// - port write lands in output latch
// - direction one means input, resets one
// - input-only direction bit reads one
// - latch holds bits two to zero
// - analog select zero means digital input
// - small variant reads pins two-zero zero
// - port write replaces the output latch with the write word
// - input-only pin reads zero as master clear
`timescale 1ns/1ps
module fpp_port (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [3:0] pin_in_i,
    output logic [2:0] pin_out_o,
    output logic [2:0] pin_oe_n_o,
    output logic [2:0] digital_in_en_o,
    output logic [3:0] pin_sense_o,
    input wire logic [2:0] lcd_seg_en_i,
    input wire logic [2:0] lcd_seg_val_i,
    input wire logic [2:0] ccp_en_i,
    input wire logic [2:0] ccp_val_i,
    input wire logic small_variant_i,
    input wire logic master_clear_pin_select_i
);
    logic [2:0] port_direction_ff;
    // the zero only keeps simulation defined; no system reset clears it
    logic [2:0] port_output_latch_ff = fpp_pkg::LATCH_RST;
    logic [2:0] port_analog_select_ff;
    logic [7:0] reg_rdata_ff;
    logic [7:0] nxt_rdata;
    logic [3:0] port_pin_levels;
    logic [2:0] drive;
    logic [2:0] drv_val;
    logic wr_dir;
    logic wr_lat;
    logic wr_ans;
    logic wr_port;
    fpp_pkg::fpp_req_t req;

    assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i,
                   wdata: reg_wdata_i};

    // decoding shared by every write path
    function automatic logic hit(input fpp_pkg::fpp_req_t r,
                                 input logic [3:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction : hit

    assign wr_port = hit(req, fpp_pkg::OFS_PIN_LEVELS);
    assign wr_dir = hit(req, fpp_pkg::OFS_DIRECTION);
    assign wr_lat = hit(req, fpp_pkg::OFS_OUTPUT_LATCH);
    assign wr_ans = hit(req, fpp_pkg::OFS_ANALOG_SELECT);

    // direction bits, one means tri-stated input
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            port_direction_ff <= fpp_pkg::DIRECTION_RST;
        end else if (wr_dir) begin
            port_direction_ff <= req.wdata[2:0];
        end
    end

    // analog select comes up set so pins start as analog inputs
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            port_analog_select_ff <= fpp_pkg::ANALOG_SELECT_RST;
        end else if (wr_ans) begin
            port_analog_select_ff <= req.wdata[2:0];
        end
    end

    // port writes land in the latch, never on the pins; the write word
    // replaces the latch, as an rmw of the pins by the cpu would
    always_ff @(posedge mclk_i) begin
        if (wr_port || wr_lat) begin
            port_output_latch_ff <= req.wdata[2:0];
        end
    end

    // digital pin view: analog pins, master clear and small variant
    always_comb begin
        for (int i = 0; i < fpp_pkg::NUM_IO; i++) begin
            port_pin_levels[i] = pin_in_i[i] &
                ~port_analog_select_ff[i] & ~small_variant_i;
        end
        port_pin_levels[fpp_pkg::INPUT_ONLY_IDX] =
            pin_in_i[fpp_pkg::INPUT_ONLY_IDX] &
            ~master_clear_pin_select_i;
    end

    // analog and peripheral inputs see the raw pin in every direction
    assign pin_sense_o = pin_in_i;
    assign digital_in_en_o = ~port_analog_select_ff;

    // one output selector per bidirectional pin
    genvar g;
    generate
        for (g = 0; g < fpp_pkg::NUM_IO; g++) begin : g_pin
            fpp_pin_mux u_mux (
                .lcd_i('{en: lcd_seg_en_i[g], val: lcd_seg_val_i[g]}),
                .ccp_i('{en: ccp_en_i[g], val: ccp_val_i[g]}),
                .latch_i(port_output_latch_ff[g]),
                .dir_input_i(port_direction_ff[g]),
                .drive_o(drive[g]),
                .val_o(drv_val[g])
            );
        end
    endgenerate

    // small variant has no bidirectional pins, so nothing drives
    assign pin_oe_n_o = ~(drive & {3{~small_variant_i}});
    assign pin_out_o = drv_val;

    // read mux; unmapped offsets and unused upper bits read zero
    always_comb begin
        nxt_rdata = fpp_pkg::READ_ZERO;
        if (req.rd) begin
            unique case (req.addr)
                fpp_pkg::OFS_PIN_LEVELS:
                    nxt_rdata[3:0] = port_pin_levels;
                fpp_pkg::OFS_DIRECTION: begin
                    nxt_rdata[3] = 1'b1;
                    nxt_rdata[2:0] = small_variant_i ?
                        3'h0 : port_direction_ff;
                end
                fpp_pkg::OFS_OUTPUT_LATCH:
                    nxt_rdata[2:0] = small_variant_i ?
                        3'h0 : port_output_latch_ff;
                fpp_pkg::OFS_ANALOG_SELECT:
                    nxt_rdata[2:0] = small_variant_i ?
                        3'h0 : port_analog_select_ff;
                default: nxt_rdata = fpp_pkg::READ_ZERO;
            endcase
        end
    end

    // read data stand one cycle after the strobe only
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            reg_rdata_ff <= fpp_pkg::READ_ZERO;
        end else begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_o = reg_rdata_ff;
endmodule : fpp_port

/* fpp_sva.sv */
// checker: port read-back and pin drive relations
`timescale 1ns/1ps
module fpp_sva (
    input wire logic mclk_i, sys_rst_i, reg_wr_i, reg_rd_i,
    input wire logic small_variant_i, master_clear_pin_select_i,
    input wire logic [3:0] reg_addr_i, pin_in_i,
    input wire logic [7:0] reg_wdata_i, reg_rdata_o,
    input wire logic [2:0] pin_out_o, pin_oe_n_o, digital_in_en_o,
    input wire logic [2:0] lcd_seg_en_i, lcd_seg_val_i, ccp_en_i, ccp_val_i
);
    // owned pins, owner value, read address and the expected port read
    wire [2:0] own = (lcd_seg_en_i | ccp_en_i) & {3{!small_variant_i}};
    wire [2:0] per = lcd_seg_en_i & lcd_seg_val_i | ~lcd_seg_en_i & ccp_val_i;
    wire [2:0] wd = reg_wdata_i[2:0];
    wire [2:0] ans = ~digital_in_en_o;
    wire [3:0] rda = reg_rd_i ? reg_addr_i : 4'hf;
    wire [7:0] pins = {4'h0, pin_in_i[3] & ~master_clear_pin_select_i,
        pin_in_i[2:0] & digital_in_en_o & {3{~small_variant_i}}};
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_wr(a); reg_wr_i && reg_addr_i == a; endsequence
    sequence s_free; own == 3'h0 && !small_variant_i; endsequence
    property p_pin; rda == 4'h0 |=> reg_rdata_o == $past(pins); endproperty
    a_pin: assert property (p_pin) else $error("port read");
    property p_dir_rd; rda == 4'h1 |=> reg_rdata_o[7:3] == 5'h01; endproperty
    a_dir_rd: assert property (p_dir_rd) else $error("dir read");
    property p_ans; rda == 4'h3 && !small_variant_i
        |=> reg_rdata_o == {5'h00, $past(ans)}; endproperty
    a_ans: assert property (p_ans) else $error("ans read");
    property p_prio; (pin_out_o & own) == (per & own); endproperty
    a_prio: assert property (p_prio) else $error("priority");
    property p_oe; (pin_oe_n_o & own) == 3'h0; endproperty
    a_oe: assert property (p_oe) else $error("owner drive");
    property p_dir; s_wr(4'h1) ##1 s_free
        |-> pin_oe_n_o == $past(wd); endproperty
    a_dir: assert property (p_dir) else $error("dir drive");
    property p_lat; s_wr(4'h2) ##1 s_free
        |-> (pin_out_o | pin_oe_n_o) == ($past(wd) | pin_oe_n_o); endproperty
    a_lat: assert property (p_lat) else $error("latch drive");
    property p_rst; $fell(sys_rst_i) && !small_variant_i
        |-> ans == 3'h7; endproperty
    a_rst: assert property (p_rst) else $error("ans reset");
endmodule : fpp_sva

/* fpp_pad.sv */
// pad model: outside source on released pins, port value on driven ones
`timescale 1ns/1ps
module fpp_pad (
    input wire logic [2:0] out_i,
    input wire logic [2:0] oe_n_i,
    output logic [3:0] pad_o
);
    // outside source holds all pins high while the port lets go
    assign pad_o = {1'b1, out_i & ~oe_n_i | oe_n_i};
endmodule : fpp_pad

/* fpp_tb.sv */
// testbench: register and pin drive scenarios for the port
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
$display("[ERR] %0t got %h want %h", $time, g, e); end end
module testbench;
    logic mclk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
    logic small_variant_i = 0, master_clear_pin_select_i = 0;
    logic [3:0] reg_addr_i = 4'h0, pin_in_i, pin_sense_o;
    logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
    logic [2:0] pin_out_o, pin_oe_n_o, digital_in_en_o;
    logic [2:0] lcd_seg_en_i = '0, lcd_seg_val_i = '0;
    logic [2:0] ccp_en_i = '0, ccp_val_i = '0;
    int mismatches = 0, compares = 0;
    fpp_port dut_u (.*);
    fpp_pad pad_u (.out_i(pin_out_o), .oe_n_i(pin_oe_n_o), .pad_o(pin_in_i));
    // 200 MHz clock; a cycle ceiling cuts a hang short
    always #2.5 mclk_i = ~mclk_i;
    initial begin
        repeat (2000) @(posedge mclk_i);
        mismatches++;
        tally_and_finish();
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    // data stand only in the cycle after the strobe, so judge it there
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 `CHK(reg_rdata_o, e)
    endtask : rd
    task automatic t_regs();
        rd(4'h1, 8'h0f);
        rd(4'h3, 8'h07);
        rd(4'h0, 8'h08);
        master_clear_pin_select_i <= 1'b1;
        rd(4'h0, 8'h00);
        {master_clear_pin_select_i, small_variant_i} <= 2'h1;
        rd(4'h1, 8'h08);
        rd(4'h3, 8'h00);
        small_variant_i <= 1'b0;
        wr(4'h9, 8'hff);
        rd(4'h9, 8'h00);
        $display("register test done");
    endtask : t_regs
    task automatic t_drive();
        wr(4'h3, 8'h00);
        wr(4'h1, 8'hf8);
        wr(4'h0, 8'hfd);
        rd(4'h0, 8'h0d);
        rd(4'h2, 8'h05);
        wr(4'h3, 8'hff);
        rd(4'h0, 8'h08);
        `CHK({pin_oe_n_o, pin_out_o, pin_sense_o}, 10'h05d)
        wr(4'h2, 8'hfa);
        rd(4'h2, 8'h02);
        $display("drive test done");
    endtask : t_drive
    // latch holds 2: lcd over ccp, ccp over latch, latch alone, then mixed owners with direction set to input
    task automatic t_prio();
        logic [11:0] st [4] = '{12'hf7a, 12'h0bd, 12'h085, 12'h258};
        logic [5:0] ex [4] = '{6'h05, 6'h05, 6'h02, 6'h21};
        for (int i = 0; i < 4; i++) begin
            if (i == 3) wr(4'h1, 8'h07);
            @(posedge mclk_i);
            {lcd_seg_en_i, lcd_seg_val_i, ccp_en_i, ccp_val_i} <= st[i];
            #1 `CHK({pin_oe_n_o, pin_out_o}, ex[i])
        end
        $display("priority test done");
    endtask : t_prio
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    // reset for three cycles, then the scenarios in turn
    initial begin
        repeat (3) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_drive();
        t_prio();
        tally_and_finish();
    end
endmodule : testbench
bind fpp_port fpp_sva chk_u (.*);
